//--- opcs_pkg.sv
// Purpose: constants for the output polarity and clock status register slice
// Assumes: byte-wide register port, 8-bit addresses
// Notes: offsets are byte addresses of the control port
package opcs_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OPCS_ADDR_POLARITY = 8'h57; // polarity control
    localparam logic [7:0] OPCS_ADDR_DIE_ID = 8'h58; // die identification
    localparam logic [7:0] OPCS_ADDR_VOL_STATUS = 8'h59; // volume ramp status
    localparam logic [7:0] OPCS_ADDR_RATE_RATIO = 8'h5B; // rate and ratio
    localparam logic [7:0] OPCS_ADDR_BCLK_HIGH = 8'h5C; // bit clock ratio msb
    localparam logic [7:0] OPCS_ADDR_BCLK_LOW = 8'h5D; // bit clock ratio lsb
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int OPCS_BIT_PIN_TWO_INV = 5;
    localparam int OPCS_BIT_MUTE_INV = 4;
    localparam int OPCS_BIT_PIN_ZERO_INV = 3;
    localparam int OPCS_BIT_LEFT_RAMPING = 5;
    localparam int OPCS_BIT_LEFT_ARRIVED = 4;
    localparam int OPCS_BIT_RIGHT_RAMPING = 1;
    localparam int OPCS_BIT_RIGHT_ARRIVED = 0;
    localparam int OPCS_BIT_BCLK_MSB = 1;
    localparam int OPCS_BIT_BCLK_LSB = 7;
    // ----------------------------------------------------------------
    // reset values and identity
    // ----------------------------------------------------------------
    localparam logic [7:0] OPCS_RST_POLARITY = 8'h00;
    localparam logic [7:0] OPCS_RST_STATUS = 8'h00;
    // identity value is arbitrary
    localparam logic [7:0] OPCS_DIE_ID_DEFAULT = 8'h5A;
    // sample rate codes
    localparam logic [2:0] OPCS_FS_ERROR = 3'h0;
    localparam logic [2:0] OPCS_FS_384K = 3'h6;
    // ratio code meaning a disallowed ratio
    localparam logic [3:0] OPCS_RATIO_ERROR = 4'h0;
    localparam logic [3:0] OPCS_RATIO_MAX = 4'hE;
    // width of the bit clock ratio value
    localparam int OPCS_BCLK_W = 9;
endpackage : opcs_pkg

//--- opcs_pin_pol.sv
// Purpose: polarity stage for one output pin
// Assumes: source already selected upstream
// Notes: purely combinational
`timescale 1ns/10ps
`default_nettype none
module opcs_pin_pol (
    // source and polarity
    input wire logic sel_i,
    input wire logic inv_i,
    // pin level
    output logic pin_o
);
    // invert after selection
    assign pin_o = sel_i ^ inv_i; // RULE_04
endmodule : opcs_pin_pol
`default_nettype wire

//--- opcs_regs.sv
// Purpose: output polarity control and clock/volume status registers
// Assumes: byte register port from the control-port decoder, sync inputs
// Notes: status fields are live detector outputs, sampled each clock
//
// Notes on behaviour
// RULE_01 - bit 5 inverts general pin two
// RULE_02 - bit 4 inverts the mute pin
// RULE_03 - bit 3 inverts general pin zero
// RULE_04 - inversion applies after source selection
// RULE_05 - left ramping flag reads at bit 5
// RULE_06 - left arrived flag reads at bit 4
// RULE_07 - right ramping flag reads at bit 1
// RULE_08 - right arrived flag reads at bit 0
// RULE_09 - detected sample rate code at bits 6-4
// RULE_10 - detected master clock ratio at bits 3-0
// RULE_11 - clock error possible despite valid ratio
// RULE_12 - source gives enough ratio without PLL
// RULE_13 - master clock stays below 50 MHz
// RULE_14 - bit clock ratio msb at bit 1
// RULE_15 - bit clock ratio lsb at bit 7 next
// RULE_16 - writes to status fields are ignored
`timescale 1ns/10ps
`default_nettype none
module opcs_regs
    import opcs_pkg::*;
#(
    parameter logic [7:0] DIE_ID = OPCS_DIE_ID_DEFAULT // arbitrary value
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // selected pin sources
    input wire logic pin_two_src_i,
    input wire logic mute_src_i,
    input wire logic pin_zero_src_i,
    // volume ramp status
    input wire logic left_volume_ramping_i,
    input wire logic left_volume_arrived_i,
    input wire logic right_volume_ramping_i,
    input wire logic right_volume_arrived_i,
    // clock detectors
    input wire logic [2:0] detected_sample_rate_i,
    input wire logic [3:0] detected_master_ratio_i,
    input wire logic [8:0] detected_bit_clock_ratio_i,
    input wire logic clock_combo_err_i,
    // pins
    output logic general_pin_two_o,
    output logic mute_pin_o,
    output logic general_pin_zero_o,
    // clock error summary
    output logic clock_error_o
);
    import opcs_pkg::*;

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    logic [7:0] polarity_q; // whole byte is writable
    logic [7:0] polarity_d;
    logic [7:0] vol_res_q; // reserved r/w bits 7-6, 3-2
    logic [7:0] vol_res_d;
    logic rate_res_q; // reserved r/w bit 7
    logic rate_res_d;
    logic [5:0] bhigh_res_q; // reserved r/w bits 7-3, 0; bit 2 reads zero
    logic [5:0] bhigh_res_d;
    logic [6:0] blow_res_q; // reserved r/w bits 6-0
    logic [6:0] blow_res_d;

    // write strobes per address
    wire wr_pol = reg_wr_i && (reg_addr_i == OPCS_ADDR_POLARITY);
    wire wr_vol = reg_wr_i && (reg_addr_i == OPCS_ADDR_VOL_STATUS);
    wire wr_rate = reg_wr_i && (reg_addr_i == OPCS_ADDR_RATE_RATIO);
    wire wr_bhi = reg_wr_i && (reg_addr_i == OPCS_ADDR_BCLK_HIGH);
    wire wr_blo = reg_wr_i && (reg_addr_i == OPCS_ADDR_BCLK_LOW);

    // polarity takes the whole byte; status bytes take write data in reserved bits only, status bits are live
    assign polarity_d = wr_pol ? reg_wdata_i : polarity_q;
    assign vol_res_d = wr_vol ? (reg_wdata_i & 8'hCC) : vol_res_q; // RULE_16
    assign rate_res_d = wr_rate ? reg_wdata_i[7] : rate_res_q; // RULE_16
    assign bhigh_res_d = wr_bhi ? {reg_wdata_i[7:3], reg_wdata_i[0]}
                                : bhigh_res_q; // RULE_16
    assign blow_res_d = wr_blo ? reg_wdata_i[6:0] : blow_res_q; // RULE_16

    // ------------------------------------------------------------
    // status sampling
    // ------------------------------------------------------------
    logic [3:0] vol_q; // left ramp, left arr, right ramp, right arr
    logic [2:0] rate_q;
    logic [3:0] ratio_q;
    logic [8:0] bclk_q;
    logic combo_q;

    // control register update
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            polarity_q <= OPCS_RST_POLARITY;
            vol_res_q <= OPCS_RST_STATUS;
            rate_res_q <= 1'b0;
            bhigh_res_q <= 6'h00;
            blow_res_q <= 7'h00;
        end else begin
            polarity_q <= polarity_d;
            vol_res_q <= vol_res_d;
            rate_res_q <= rate_res_d;
            bhigh_res_q <= bhigh_res_d;
            blow_res_q <= blow_res_d;
        end
    end

    // status fields follow detectors every clock
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            vol_q <= 4'h0;
            rate_q <= OPCS_FS_ERROR;
            ratio_q <= OPCS_RATIO_ERROR;
            bclk_q <= 9'h000;
            combo_q <= 1'b0;
        end else begin
            vol_q <= {left_volume_ramping_i, left_volume_arrived_i,
                      right_volume_ramping_i, right_volume_arrived_i}; // RULE_16
            rate_q <= detected_sample_rate_i; // RULE_09
            ratio_q <= detected_master_ratio_i; // RULE_10
            bclk_q <= detected_bit_clock_ratio_i; // RULE_15
            combo_q <= clock_combo_err_i;
        end
    end

    // ------------------------------------------------------------
    // clock error flag
    // ------------------------------------------------------------
    // bad rate, bad ratio, or a valid ratio unusable at this rate
    wire rate_bad = (rate_q == OPCS_FS_ERROR) || (rate_q > OPCS_FS_384K);
    wire ratio_bad = (ratio_q == OPCS_RATIO_ERROR) || (ratio_q > OPCS_RATIO_MAX);
    assign clock_error_o = rate_bad || ratio_bad || combo_q; // RULE_11

    // ------------------------------------------------------------
    // read data assembly
    // ------------------------------------------------------------
    wire [7:0] vol_byte;
    wire [7:0] rate_byte;
    wire [7:0] bhigh_byte;
    wire [7:0] blow_byte;
    wire [7:0] rd_mux;

    // volume status byte
    assign vol_byte = vol_res_q |
        (8'(vol_q[3]) << OPCS_BIT_LEFT_RAMPING) | // RULE_05
        (8'(vol_q[2]) << OPCS_BIT_LEFT_ARRIVED) | // RULE_06
        (8'(vol_q[1]) << OPCS_BIT_RIGHT_RAMPING) | // RULE_07
        (8'(vol_q[0]) << OPCS_BIT_RIGHT_ARRIVED); // RULE_08
    // rate and ratio byte
    assign rate_byte = {rate_res_q, rate_q, ratio_q}; // RULE_09
    // bit clock ratio msb byte
    assign bhigh_byte = {bhigh_res_q[5:1], 1'b0,
        bclk_q[OPCS_BCLK_W-1], bhigh_res_q[0]}; // RULE_14
    // bit clock ratio lsb byte
    assign blow_byte = {bclk_q[0], blow_res_q}; // RULE_15

    // address select, unmapped reads zero
    assign rd_mux =
        (reg_addr_i == OPCS_ADDR_POLARITY) ? polarity_q :
        (reg_addr_i == OPCS_ADDR_DIE_ID) ? DIE_ID :
        (reg_addr_i == OPCS_ADDR_VOL_STATUS) ? vol_byte :
        (reg_addr_i == OPCS_ADDR_RATE_RATIO) ? rate_byte :
        (reg_addr_i == OPCS_ADDR_BCLK_HIGH) ? bhigh_byte :
        (reg_addr_i == OPCS_ADDR_BCLK_LOW) ? blow_byte : 8'h00;

    // registered read answer
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rdata_o <= reg_rd_i ? rd_mux : reg_rdata_o;
            reg_rvalid_o <= reg_rd_i;
        end
    end

    // ------------------------------------------------------------
    // pin polarity stages
    // ------------------------------------------------------------
    opcs_pin_pol u_pol_two (
        .sel_i(pin_two_src_i),
        .inv_i(polarity_q[OPCS_BIT_PIN_TWO_INV]), // RULE_01
        .pin_o(general_pin_two_o)
    );
    opcs_pin_pol u_pol_mute (
        .sel_i(mute_src_i),
        .inv_i(polarity_q[OPCS_BIT_MUTE_INV]), // RULE_02
        .pin_o(mute_pin_o)
    );
    opcs_pin_pol u_pol_zero (
        .sel_i(pin_zero_src_i),
        .inv_i(polarity_q[OPCS_BIT_PIN_ZERO_INV]), // RULE_03
        .pin_o(general_pin_zero_o)
    );
endmodule : opcs_regs
`default_nettype wire

//--- opcs_src_model.sv
// Purpose: far-side volume ramp and clock detector model
// Assumes: mode_i selects one detector state
// Notes: levels are registered, one cycle behind mode_i
`timescale 1ns/10ps
`default_nettype none
module opcs_src_model (
    // clock and state selector
    input wire logic clk_i,
    input wire logic [3:0] mode_i,
    // detector levels
    output logic [3:0] vol_o,
    output logic [2:0] rate_o,
    output logic [3:0] ratio_o,
    output logic [8:0] bclk_o,
    output logic combo_o
);
    // ratio is capped at 1110, code 1111 is never sent, code 0000 still is
    always_ff @(posedge clk_i) begin
        vol_o <= mode_i;
        rate_o <= (mode_i[2:0] == 3'h7) ? 3'h6 : mode_i[2:0];
        ratio_o <= (mode_i == 4'hF) ? 4'hE : mode_i;
        bclk_o <= {mode_i, ~mode_i[0], mode_i};
        combo_o <= (mode_i == 4'h5);
    end
endmodule : opcs_src_model
`default_nettype wire

//--- opcs_regs_sva.sv
// Purpose: port-level checks for the polarity and status registers
// Assumes: reads answer one cycle after the read edge
// Notes: status reads show inputs from one edge before the read edge
`timescale 1ns/10ps
`default_nettype none
module opcs_regs_sva (
    // clock, reset and register port
    input wire logic clk_i, rst_n_i, reg_wr_i, reg_rd_i, reg_rvalid_o,
    input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
    // pins and sources
    input wire logic pin_two_src_i, mute_src_i, pin_zero_src_i,
    input wire logic general_pin_two_o, mute_pin_o, general_pin_zero_o,
    // status inputs and summary
    input wire logic left_volume_ramping_i, left_volume_arrived_i,
    input wire logic right_volume_ramping_i, right_volume_arrived_i,
    input wire logic [2:0] detected_sample_rate_i,
    input wire logic [3:0] detected_master_ratio_i,
    input wire logic [8:0] detected_bit_clock_ratio_i,
    input wire logic clock_combo_err_i, clock_error_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic live_q; // reset level one edge back
    always_ff @(posedge clk_i) live_q <= rst_n_i;
    wire logic wr_pol = reg_wr_i && (reg_addr_i == 8'h57);
    a_pin_two_inv: assert property (wr_pol |=> general_pin_two_o ==
        (pin_two_src_i ^ $past(reg_wdata_i[5]))) else $error("pin two level");
    a_mute_inv: assert property (wr_pol |=> mute_pin_o ==
        (mute_src_i ^ $past(reg_wdata_i[4]))) else $error("mute pin level");
    a_pin_zero_inv: assert property (wr_pol |=> general_pin_zero_o ==
        (pin_zero_src_i ^ $past(reg_wdata_i[3]))) else $error("pin zero level");
    a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read not answered");
    a_vol_status: assert property (reg_rd_i && reg_addr_i == 8'h59 && live_q
        |=> {reg_rdata_o[5:4], reg_rdata_o[1:0]} == $past({left_volume_ramping_i,
        left_volume_arrived_i, right_volume_ramping_i, right_volume_arrived_i}, 2))
        else $error("volume status");
    a_rate_ratio: assert property (reg_rd_i && reg_addr_i == 8'h5B && live_q |=>
        reg_rdata_o[6:0] == $past({detected_sample_rate_i, detected_master_ratio_i}, 2))
        else $error("rate and ratio");
    a_bclk_msb: assert property (reg_rd_i && reg_addr_i == 8'h5C && live_q |=>
        reg_rdata_o[1] == $past(detected_bit_clock_ratio_i[8], 2)) else $error("bclk msb");
    a_clock_err: assert property (clock_combo_err_i || detected_sample_rate_i == 3'h0
        |=> clock_error_o) else $error("clock error not raised");
    cover property (wr_pol);
    cover property (reg_rd_i && reg_addr_i == 8'h5B);
    cover property (clock_combo_err_i && detected_master_ratio_i != 4'h0);
endmodule : opcs_regs_sva
`default_nettype wire

//--- testbench.sv
// Purpose: self-checking bench for the polarity and status registers
// Assumes: detector model on the status inputs
// Notes: one task per scenario
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import opcs_pkg::*;
    logic clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, d;
    logic pin_two_src_i = 1'b0, mute_src_i = 1'b0, pin_zero_src_i = 1'b0;
    logic [3:0] mode = 4'h0;
    wire logic left_volume_ramping_i, left_volume_arrived_i, clock_combo_err_i;
    wire logic right_volume_ramping_i, right_volume_arrived_i;
    wire logic [2:0] detected_sample_rate_i;
    wire logic [3:0] detected_master_ratio_i;
    wire logic [8:0] detected_bit_clock_ratio_i;
    logic reg_rvalid_o, general_pin_two_o, mute_pin_o, general_pin_zero_o;
    logic clock_error_o;
    int n_mismatch = 0, n_checks = 0;
    always #2 clk_i = ~clk_i;
    opcs_regs DUT (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o),
        .pin_two_src_i(pin_two_src_i),
        .mute_src_i(mute_src_i),
        .pin_zero_src_i(pin_zero_src_i),
        .left_volume_ramping_i(left_volume_ramping_i),
        .left_volume_arrived_i(left_volume_arrived_i),
        .right_volume_ramping_i(right_volume_ramping_i),
        .right_volume_arrived_i(right_volume_arrived_i),
        .detected_sample_rate_i(detected_sample_rate_i),
        .detected_master_ratio_i(detected_master_ratio_i),
        .detected_bit_clock_ratio_i(detected_bit_clock_ratio_i),
        .clock_combo_err_i(clock_combo_err_i),
        .general_pin_two_o(general_pin_two_o),
        .mute_pin_o(mute_pin_o),
        .general_pin_zero_o(general_pin_zero_o),
        .clock_error_o(clock_error_o)
    );
    opcs_src_model u_src (.clk_i(clk_i), .mode_i(mode), .vol_o({left_volume_ramping_i,
        left_volume_arrived_i, right_volume_ramping_i, right_volume_arrived_i}),
        .rate_o(detected_sample_rate_i), .ratio_o(detected_master_ratio_i),
        .bclk_o(detected_bit_clock_ratio_i), .combo_o(clock_combo_err_i));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] w);
        @(posedge clk_i);
        {reg_wr_i, reg_rd_i} <= {wr, ~wr};
        reg_addr_i <= a;
        reg_wdata_i <= w;
        @(posedge clk_i);
        {reg_wr_i, reg_rd_i} <= 2'b00;
        #1 d = reg_rdata_o;
        if (!wr) chk({7'h00, reg_rvalid_o}, 8'h01);
    endtask : acc
    task automatic t_polarity();
        acc(1'b0, OPCS_ADDR_POLARITY, 8'h00);
        chk(d, OPCS_RST_POLARITY);
        for (int i = 0; i < 8; i++) begin
            acc(1'b1, OPCS_ADDR_POLARITY, {2'h0, i[2:0], 3'h0});
            @(posedge clk_i);
            {pin_two_src_i, mute_src_i, pin_zero_src_i} <= i[2:0] ^ 3'h5;
            #1 chk({5'h00, general_pin_two_o, mute_pin_o, general_pin_zero_o},
                {5'h00, 3'h5});
        end
    endtask : t_polarity
    task automatic t_status();
        for (int m = 0; m < 16; m++) begin
            @(posedge clk_i);
            mode <= m[3:0];
            acc(1'b1, OPCS_ADDR_VOL_STATUS, 8'hFF);
            acc(1'b1, OPCS_ADDR_RATE_RATIO, 8'h7F);
            acc(1'b0, OPCS_ADDR_VOL_STATUS, 8'h00);
            chk(d & 8'h33, {2'h0, m[3:2], 2'h0, m[1:0]});
            chk(d & 8'hCC, 8'hCC);
            acc(1'b0, OPCS_ADDR_RATE_RATIO, 8'h00);
            chk({1'b0, d[6:4]}, {5'h00, (m[2:0] == 3'h7) ? 3'h6 : m[2:0]});
            chk({4'h0, d[3:0]}, {4'h0, (m[3:0] == 4'hF) ? 4'hE : m[3:0]});
            chk({7'h00, d[7]}, 8'h00);
            acc(1'b0, OPCS_ADDR_BCLK_HIGH, 8'h00);
            chk({7'h00, d[1]}, {7'h00, m[3]});
            acc(1'b0, OPCS_ADDR_BCLK_LOW, 8'h00);
            chk({7'h00, d[7]}, {7'h00, m[0]});
            chk({7'h00, clock_error_o}, {7'h00, m == 5 || m[2:0] == 0});
        end
    endtask : t_status
    // mid-run reset returns polarity to zero
    task automatic t_reset();
        acc(1'b1, OPCS_ADDR_POLARITY, 8'h38);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1 chk({7'h00, clock_error_o}, 8'h01);
        chk({5'h00, general_pin_two_o, mute_pin_o, general_pin_zero_o},
            {5'h00, pin_two_src_i, mute_src_i, pin_zero_src_i});
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        acc(1'b0, OPCS_ADDR_POLARITY, 8'h00);
        chk(d, OPCS_RST_POLARITY);
    endtask : t_reset
    task automatic complete_run();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_polarity();
        t_status();
        t_reset();
        complete_run();
    end
    initial begin
        #20000 n_mismatch++;
        complete_run();
    end
endmodule : testbench
bind opcs_regs opcs_regs_sva u_sva (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rvalid_o(reg_rvalid_o),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .pin_two_src_i(pin_two_src_i),
    .mute_src_i(mute_src_i),
    .pin_zero_src_i(pin_zero_src_i),
    .general_pin_two_o(general_pin_two_o),
    .mute_pin_o(mute_pin_o),
    .general_pin_zero_o(general_pin_zero_o),
    .left_volume_ramping_i(left_volume_ramping_i),
    .left_volume_arrived_i(left_volume_arrived_i),
    .right_volume_ramping_i(right_volume_ramping_i),
    .right_volume_arrived_i(right_volume_arrived_i),
    .detected_sample_rate_i(detected_sample_rate_i),
    .detected_master_ratio_i(detected_master_ratio_i),
    .detected_bit_clock_ratio_i(detected_bit_clock_ratio_i),
    .clock_combo_err_i(clock_combo_err_i),
    .clock_error_o(clock_error_o)
);
`default_nettype wire
